// File: logic/esc_shift_chain.sv
// Eight-bit shift chain function unit with configurable output tap and retention.
// Assumes program logic on the same clock drives the control inputs, and that a
// power-restore pulse marks the first cycle after supply returns.
//
// Contract
// [R1] Each strobe rising edge samples data and shifts the chain exactly once; the code shifts only in run mode and not in a power-restore pulse cycle.
// [R2] Strobe falling edges leave chain and output untouched.
// [R3] Sense level at the edge picks direction: 0 up, 1 down.
// [R4] Up: data enters bit 1, each bit moves up, old bit 8 lost.
// [R5] Down: data enters bit 8, each bit moves down, old bit 1 lost.
// [R6] A wipe rising edge clears all eight chain bits; the code clears on it only in run mode and not in a power-restore pulse cycle.
// [R7] Output always shows the configured chain bit of the configured chain index.
// [R8] At most 32 chain bits overall, eight per chain.
// [R9] No more than four chains exist in one program.
// [R10] With retention on, every chain bit survives a power failure.
// [R11] With retention off, the chain restarts cleared after a power failure.
// [R12] Chain index and tap are set only while programming, never at run time.
// [R13] Wipe and strobe edges together: clear wins, no shift.
`timescale 1ns/10ps
module esc_shift_chain #(
   parameter int CHAIN_BITS = esc_pkg::CHAIN_BITS,
   parameter int CHAIN_SLOT = 1
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst,
   // Program logic inputs.
   input  wire esc_pkg::esc_ctl_t ctl,
   // Mode and power events.
   input  wire logic              progMode,
   input  wire logic              powerRestore,
   // Programming-time configuration.
   input  wire esc_pkg::esc_cfg_t cfgIn,
   input  wire logic              cfgLoad,
   // Results.
   output logic [7:0]             chainBits,
   output logic                   selBit,
   output logic [1:0]             cfgIdx,
   output logic                   running
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   // The tap selector is three bits wide, so only an eight-bit chain can be served.
   if (CHAIN_BITS != esc_pkg::CHAIN_BITS) begin : g_bits_chk
      $error("Chain width must be eight bits.");
   end
   if (CHAIN_BITS * esc_pkg::MAX_CHAINS != esc_pkg::TOTAL_BITS) begin : g_total_chk // R8
      $error("Chains must add up to 32 bits.");
   end
   if (CHAIN_SLOT < 1 || CHAIN_SLOT > esc_pkg::MAX_CHAINS) begin : g_slot_chk // R9
      $error("Chain slot must lie in 1 to 4.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // One shift step in the chosen direction.
   function automatic logic [7:0] shiftStep(input logic [7:0] cur,
                                            input logic       dir,
                                            input logic       din);
      logic [7:0] res;
      if (dir == esc_pkg::DIR_UP) begin
         res = {cur[6:0], din};
      end else begin
         res = {din, cur[7:1]};
      end
      return res;
   endfunction

   // Picks the tapped bit.
   function automatic logic tapBit(input logic [7:0] cur, input logic [2:0] sel);
      return cur[sel];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection.

   logic [1:0] rise;
   logic       strobeRise;
   logic       wipeRise;

   // Strobe and wipe share one detector; falling edges produce nothing.
   esc_edge_det #(
      .W (2)
   ) u_edge (
      .clk   (clk),
      .rst   (rst),
      .level ({ctl.wipe, ctl.strobe}),
      .rise  (rise)
   );

   // Named views of the two edge bits.
   assign strobeRise = rise[0]; // R2
   assign wipeRise   = rise[1];

   ////////////////////////////////////////////////////////////////////////////
   // Mode and chain state.

   esc_pkg::esc_mode_t modeQ;
   esc_pkg::esc_mode_t modeD;
   logic [7:0]         chainQ;
   logic [7:0]         chainD;
   logic               selBitQ;
   logic               selBitD;
   logic               runD;
   logic               runQ;
   esc_pkg::esc_cfg_t  cfgQ;
   esc_pkg::esc_cfg_t  cfgD;

   // Next mode and chain; a power-restore pulse overrides any edge in its cycle,
   // since program logic has not yet produced a valid cycle then.
   always_comb begin
      modeD  = modeQ;
      chainD = chainQ;
      unique case (modeQ)
         esc_pkg::ESC_PROG: begin
            if (!progMode) begin
               modeD = esc_pkg::ESC_RUN;
            end
         end
         esc_pkg::ESC_RUN: begin
            if (progMode) begin
               modeD = esc_pkg::ESC_PROG;
            end
            if (wipeRise) begin
               chainD = esc_pkg::CHAIN_RST; // R6 R13
            end else if (strobeRise) begin
               chainD = shiftStep(chainQ, ctl.sense, ctl.data); // R1 R3 R4 R5
            end
         end
         esc_pkg::ESC_RESTORE: begin
            modeD = progMode ? esc_pkg::ESC_PROG : esc_pkg::ESC_RUN;
         end
         default: begin
            modeD = esc_pkg::ESC_PROG;
         end
      endcase
      if (powerRestore) begin
         modeD = esc_pkg::ESC_RESTORE;
         if (cfgQ.retainEn) begin
            chainD = chainQ; // R10
         end else begin
            chainD = esc_pkg::CHAIN_RST; // R11
         end
      end
      selBitD = tapBit(chainD, cfgD.bitSel); // R7
      runD    = (modeD == esc_pkg::ESC_RUN);
   end

   // Registers for mode, chain and the tapped output.
   always_ff @(posedge clk) begin
      if (rst) begin
         modeQ   <= esc_pkg::ESC_PROG;
         chainQ  <= esc_pkg::CHAIN_RST;
         selBitQ <= esc_pkg::SEL_RST;
         runQ    <= 1'h0;
      end else begin
         modeQ   <= modeD;
         chainQ  <= chainD; // R10
         selBitQ <= selBitD;
         runQ    <= runD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration.

   // Configuration is only taken while programming; run-time loads are ignored
   // so a running program can never retarget the tap.
   always_comb begin
      cfgD = cfgQ;
      if (modeQ == esc_pkg::ESC_PROG && cfgLoad) begin
         cfgD = cfgIn; // R12 R9
      end
   end

   // Configuration register.
   always_ff @(posedge clk) begin
      if (rst) begin
         cfgQ <= esc_pkg::CFG_RST;
      end else begin
         cfgQ <= cfgD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops.

   assign chainBits = chainQ; // R8
   assign selBit    = selBitQ;
   assign cfgIdx    = cfgQ.chainIdx;
   assign running   = runQ;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   logic shiftOnly;

   // A clean shift cycle: running, strobe edge, no wipe, no power event.
   assign shiftOnly = (modeQ == esc_pkg::ESC_RUN) && strobeRise && !wipeRise && !powerRestore;

   // Without a strobe edge, wipe or power event the chain holds still.
   property p_one_shift;
      @(posedge clk) disable iff (rst)
      (!strobeRise && !wipeRise && !powerRestore) |=> $stable(chainQ);
   endproperty
   a_one_shift: assert property (p_one_shift) else $error("Chain moved without a strobe edge."); // R1

   // A falling strobe alone changes neither chain nor output.
   property p_fall_ignored;
      @(posedge clk) disable iff (rst)
      ($fell(ctl.strobe) && !wipeRise && !powerRestore && !cfgLoad) |=> ($stable(chainQ) && $stable(selBitQ));
   endproperty
   a_fall_ignored: assert property (p_fall_ignored) else $error("Falling strobe edge had an effect."); // R2

   // Upward shift places data at bit 1 and moves the rest up by one.
   property p_shift_up;
      @(posedge clk) disable iff (rst)
      (shiftOnly && ctl.sense == esc_pkg::DIR_UP)
         |=> (chainQ[7:1] == $past(chainQ[6:0])) && (chainQ[0] == $past(ctl.data));
   endproperty
   a_shift_up: assert property (p_shift_up) else $error("Upward shift went wrong."); // R4

   // Downward shift places data at bit 8 and moves the rest down by one.
   property p_shift_down;
      @(posedge clk) disable iff (rst)
      (shiftOnly && ctl.sense == esc_pkg::DIR_DOWN)
         |=> (chainQ[6:0] == $past(chainQ[7:1])) && (chainQ[7] == $past(ctl.data));
   endproperty
   a_shift_down: assert property (p_shift_down) else $error("Downward shift went wrong."); // R5

   // The sense level alone decides which end the data enters.
   property p_dir_select;
      @(posedge clk) disable iff (rst)
      shiftOnly |=> (($past(ctl.sense) ? chainQ[7] : chainQ[0]) == $past(ctl.data));
   endproperty
   a_dir_select: assert property (p_dir_select) else $error("Direction did not follow sense."); // R3

   // A wipe edge while running empties the chain and, with no strobe, keeps it empty.
   property p_wipe;
      @(posedge clk) disable iff (rst)
      (modeQ == esc_pkg::ESC_RUN && wipeRise && !powerRestore)
         ##1 (!strobeRise && !powerRestore) |-> ##1 (chainQ == esc_pkg::CHAIN_RST);
   endproperty
   a_wipe: assert property (p_wipe) else $error("Wipe did not clear the chain."); // R6

   // Wipe and strobe edges together end with a cleared chain.
   property p_wipe_wins;
      @(posedge clk) disable iff (rst)
      (modeQ == esc_pkg::ESC_RUN && wipeRise && strobeRise && !powerRestore)
         |=> (chainQ == esc_pkg::CHAIN_RST);
   endproperty
   a_wipe_wins: assert property (p_wipe_wins) else $error("Strobe beat a simultaneous wipe."); // R13

   // The output always matches the tapped chain bit.
   property p_tap;
      @(posedge clk) disable iff (rst)
      selBitQ == chainQ[cfgQ.bitSel];
   endproperty
   a_tap: assert property (p_tap) else $error("Output does not match tapped bit."); // R7

   // A retentive unit keeps every chain bit across a power restore.
   property p_retain;
      @(posedge clk) disable iff (rst)
      (powerRestore && cfgQ.retainEn) |=> (chainQ == $past(chainQ));
   endproperty
   a_retain: assert property (p_retain) else $error("Retained chain was altered."); // R10

   // A volatile unit restarts from an empty chain after power returns.
   property p_volatile;
      @(posedge clk) disable iff (rst)
      (powerRestore && !cfgQ.retainEn) |=> (chainQ == esc_pkg::CHAIN_RST) && (modeQ == esc_pkg::ESC_RESTORE);
   endproperty
   a_volatile: assert property (p_volatile) else $error("Volatile chain was not restarted."); // R11

   // Configuration stays frozen outside programming mode for two cycles at least.
   property p_cfg_frozen;
      @(posedge clk) disable iff (rst)
      (modeQ != esc_pkg::ESC_PROG) [*2] |=> $stable(cfgQ);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("Configuration changed at run time."); // R12

   // A load during programming is taken on the next edge.
   property p_cfg_load;
      @(posedge clk) disable iff (rst)
      (modeQ == esc_pkg::ESC_PROG && cfgLoad) |=> (cfgQ == $past(cfgIn)) && (cfgIdx == $past(cfgIn.chainIdx));
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("Programming load was lost."); // R12

   // The last stage sits at the top of the eight-bit port, so a downward shift lands there.
   property p_width;
      @(posedge clk) disable iff (rst)
      (shiftOnly && ctl.sense == esc_pkg::DIR_DOWN) |=> (chainBits[esc_pkg::LAST_POS] == $past(ctl.data));
   endproperty
   a_width: assert property (p_width) else $error("Chain width is not eight."); // R8

   // The running flag matches the registered mode in the same cycle.
   property p_running;
      @(posedge clk) disable iff (rst)
      running == (modeQ == esc_pkg::ESC_RUN);
   endproperty
   a_running: assert property (p_running) else $error("Running flag disagrees with mode.");

endmodule

// File: logic/esc_pkg.sv
// Shared constants and types for the eight-bit shift chain function unit.
// Assumes one clock domain; all users reference items as esc_pkg::name.
package esc_pkg;

   // Chain geometry: eight bits per chain, at most four chains, 32 bits in all.
   localparam int CHAIN_BITS = 8;
   localparam int MAX_CHAINS = 4;
   localparam int TOTAL_BITS = 32;
   localparam int IDX_W      = 2;
   localparam int SEL_W      = 3;

   // Bit positions of the entry stages (FIRST_POS is bit 1, LAST_POS is bit 8).
   localparam int FIRST_POS = 0;
   localparam int LAST_POS  = 7;

   // Reset values.
   localparam logic [7:0] CHAIN_RST = 8'h00;
   localparam logic       SEL_RST   = 1'h0;

   // Direction encodings of the shift sense input.
   localparam logic DIR_UP   = 1'h0;
   localparam logic DIR_DOWN = 1'h1;

   // Configuration fixed at programming time.
   typedef struct packed {
      logic [1:0] chainIdx;
      logic [2:0] bitSel;
      logic       retainEn;
   } esc_cfg_t;

   localparam esc_cfg_t CFG_RST = '{chainIdx: 2'h0, bitSel: 3'h0, retainEn: 1'h0};

   // Inputs from the surrounding program logic.
   typedef struct packed {
      logic strobe;
      logic sense;
      logic data;
      logic wipe;
   } esc_ctl_t;

   // Operating modes of the function unit.
   typedef enum logic [1:0] {
      ESC_PROG    = 2'b00,
      ESC_RUN     = 2'b01,
      ESC_RESTORE = 2'b10
   } esc_mode_t;

endpackage

// File: logic/esc_edge_det.sv
// Rising edge detector for a group of same-domain control levels.
// Assumes the levels come from logic on the same clock, so no synchroniser.
`timescale 1ns/10ps
module esc_edge_det #(
   parameter int W = 2
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels and their rising edges.
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] rise
);

   logic [W-1:0] prev_q;
   logic [W-1:0] prev_d;

   // Falling edges are deliberately ignored: only 0 to 1 counts.
   always_comb begin
      prev_d = level;
      rise   = level & ~prev_q;
   end

   // History starts low, so a level already high at reset counts as an edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= prev_d;
      end
   end

endmodule

// File: verif/esc_prog_model.sv
// Behavioural model of the program logic that feeds the shift chain unit.
// Assumes one caller at a time; after the time-zero idle levels, every change lands by non-blocking assignment at a rising clock edge.
`timescale 1ns/10ps
module esc_prog_model (
   // Clock.
   input  wire logic         clk,
   // Control levels towards the unit.
   output esc_pkg::esc_ctl_t ctl
);
   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels from time zero, so no edge is seen before the first request.
   initial begin
      ctl = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Raises strobe and or wipe for hold cycles, then drops them and idles two cycles.
   // Data and sense are not held past the drop, so they show the inverse, never a stale copy.
   task automatic pulse(input logic stb, input logic wp, input logic dir, input logic d, input int hold);
      @(posedge clk);
      ctl <= '{strobe: stb, sense: dir, data: d, wipe: wp};
      repeat (hold) @(posedge clk);
      ctl <= '{strobe: 1'h0, sense: ~dir, data: ~d, wipe: 1'h0};
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule

// File: verif/esc_shift_chain_tb_top.sv
// Self-checking testbench for the eight-bit shift chain unit.
// Assumes the package and design files are compiled first; the program model drives ctl.
`timescale 1ns/10ps
module esc_shift_chain_tb_top;
   logic              clk;
   logic              rst;
   esc_pkg::esc_ctl_t ctl;
   logic              progMode;
   logic              powerRestore;
   esc_pkg::esc_cfg_t cfgIn;
   logic              cfgLoad;
   logic [7:0]        chainBits;
   logic              selBit;
   logic [1:0]        cfgIdx;
   logic              running;
   logic [7:0]        expChain;
   int                curSel;
   int                errorCnt;
   int                checksDone;

   ////////////////////////////////////////////////////////////////////////////////
   // Unit under test and its program logic partner.
   esc_shift_chain #(.CHAIN_SLOT(4)) uut (.clk(clk), .rst(rst), .ctl(ctl), .progMode(progMode),
      .powerRestore(powerRestore), .cfgIn(cfgIn), .cfgLoad(cfgLoad), .chainBits(chainBits),
      .selBit(selBit), .cfgIdx(cfgIdx), .running(running));
   esc_prog_model prog (.clk(clk), .ctl(ctl));

   // Free-running 50 ns clock.
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Waits n edges and then lets their updates land before anything is sampled.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (errorCnt == 0 && checksDone > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic setMode(input logic pm);
      @(posedge clk);
      progMode <= pm;
      cyc(3);
   endtask

   task automatic loadCfg(input esc_pkg::esc_cfg_t c);
      @(posedge clk);
      cfgIn   <= c;
      cfgLoad <= 1'h1;
      @(posedge clk);
      cfgLoad <= 1'h0;
      cyc(2);
   endtask

   // One shift through the partner, with the expected chain worked out here.
   task automatic shift(input logic dir, input logic d, input int hold);
      prog.pulse(1'h1, 1'h0, dir, d, hold);
      expChain = (dir == esc_pkg::DIR_UP) ? {expChain[6:0], d} : {d, expChain[7:1]};
      cmp(chainBits, expChain);
      cmp({7'h00, selBit}, {7'h00, expChain[curSel]});
   endtask

   // A one-cycle power restore pulse.
   task automatic powerPulse;
      @(posedge clk);
      powerRestore <= 1'h1;
      @(posedge clk);
      powerRestore <= 1'h0;
      cyc(3);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_config;
      loadCfg('{chainIdx: 2'h3, bitSel: 3'h7, retainEn: 1'h1});
      curSel = 7;
      cmp({6'h00, cfgIdx}, 8'h03);
      setMode(1'h0);
      cmp({7'h00, running}, 8'h01);
   endtask

   // Nine shifts each way so the far end bit is pushed out; strobe held short and long.
   task automatic t_up_down;
      logic [8:0] pat;
      pat = 9'h1B5;
      for (int i = 0; i < 9; i++) shift(esc_pkg::DIR_UP, pat[i], (i % 2) ? 3 : 1);
      pat = 9'h0CA;
      for (int i = 0; i < 9; i++) shift(esc_pkg::DIR_DOWN, pat[i], (i % 2) ? 1 : 3);
   endtask

   // Loads in run mode are ignored, so index and tap stay as programmed.
   task automatic t_run_cfg;
      loadCfg('{chainIdx: 2'h1, bitSel: 3'h0, retainEn: 1'h0});
      cmp({6'h00, cfgIdx}, 8'h03);
      cmp({7'h00, selBit}, {7'h00, expChain[7]});
   endtask

   // Wipe alone, then a wipe edge in the same cycle as a strobe edge.
   task automatic t_wipe;
      prog.pulse(1'h0, 1'h1, 1'h0, 1'h1, 1);
      expChain = 8'h00;
      cmp(chainBits, expChain);
      shift(esc_pkg::DIR_UP, 1'h1, 1);
      shift(esc_pkg::DIR_UP, 1'h1, 1);
      prog.pulse(1'h1, 1'h1, esc_pkg::DIR_UP, 1'h1, 2);
      expChain = 8'h00;
      cmp(chainBits, expChain);
   endtask

   // Retention on keeps every bit; retention off restarts from a clear chain.
   task automatic t_power;
      shift(esc_pkg::DIR_DOWN, 1'h1, 1);
      shift(esc_pkg::DIR_UP, 1'h1, 1);
      // A strobe edge in the restore cycle must be dropped while the chain is retained.
      fork
         powerPulse();
         prog.pulse(1'h1, 1'h0, esc_pkg::DIR_UP, 1'h0, 1);
      join
      cmp(chainBits, expChain);
      setMode(1'h1);
      for (int s = 0; s < 8; s++) begin
         loadCfg('{chainIdx: 2'h0, bitSel: s[2:0], retainEn: 1'h0});
         cmp({7'h00, selBit}, {7'h00, expChain[s]});
      end
      cmp({6'h00, cfgIdx}, 8'h00);
      setMode(1'h0);
      powerPulse();
      expChain = 8'h00;
      cmp(chainBits, expChain);
      shift(esc_pkg::DIR_UP, 1'h1, 1);
      shift(esc_pkg::DIR_DOWN, 1'h1, 2);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for six cycles, then the scenarios in order.
   initial begin
      rst          = 1'h1;
      progMode     = 1'h1;
      powerRestore = 1'h0;
      cfgLoad      = 1'h0;
      cfgIn        = esc_pkg::CFG_RST;
      expChain     = 8'h00;
      curSel       = 0;
      errorCnt     = 0;
      checksDone   = 0;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      cyc(1);
      cmp(chainBits, 8'h00);
      cmp({7'h00, running}, 8'h00);
      t_config();
      t_up_down();
      t_run_cfg();
      t_wipe();
      t_power();
      report_and_stop();
   end

   // Watchdog: the scenarios take well under a thousand cycles.
   initial begin
      #(50 * 6000);
      errorCnt++;
      report_and_stop();
   end
endmodule
